// ### core/crc16_shift_step.sv
// One conditional shift step of the reflected 16-bit checksum
`timescale 1ns/1ps

module crc16_shift_step #(
  parameter logic [15:0] POLY = rtu_crc_pkg::CRC_POLY
) (
  // Accumulator before and after the step
  input wire logic [15:0] i_crc,
  output logic [15:0] o_crc
);

  // Shift toward the LSB with zero into the MSB, fold in the polynomial on a one out
  always_comb begin
    o_crc = {1'b0, i_crc[15:1]} ^ (i_crc[0] ? POLY : 16'h0000);
  end

endmodule

// ### core/rtu_frame_crc16_engine.sv
// Checksum generator and checker for RTU frames, byte at a time, bit-serial
`timescale 1ns/1ps

module rtu_frame_crc16_engine (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Frame control
  input wire logic i_restart,
  input wire logic i_append,
  // Byte input
  input wire logic i_byte_valid,
  input wire rtu_crc_pkg::byte_in_type i_byte,
  // Checksum byte output toward the transmitter
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  // Engine status
  output logic o_byte_ready,
  output logic o_byte_done,
  output logic [15:0] o_crc,
  output logic o_check_done,
  output logic o_crc_error,
  output logic o_frame_discard
);

  rtu_crc_pkg::state_type state_reg;
  rtu_crc_pkg::state_type state_next;
  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic [15:0] crc_stepped;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic chk_hi_reg;
  logic chk_hi_next;
  logic lo_bad_reg;
  logic lo_bad_next;
  logic err_reg;
  logic err_next;
  logic ready_reg;
  logic ready_next;
  logic done_reg;
  logic done_next;
  logic chk_done_reg;
  logic chk_done_next;
  logic discard_reg;
  logic discard_next;
  logic tx_valid_reg;
  logic tx_valid_next;
  logic [7:0] tx_data_reg;
  logic [7:0] tx_data_next;
  logic take_byte;
  logic hi_bad;

  // Single shift step of the accumulator
  crc16_shift_step #(
    .POLY(rtu_crc_pkg::CRC_POLY)
  ) u_step (
    .i_crc(crc_reg),
    .o_crc(crc_stepped)
  );

  // A byte is taken only while idle and ready, so shifting is never cut short
  assign take_byte = i_byte_valid && ready_reg && (state_reg == rtu_crc_pkg::st_idle);
  assign hi_bad = i_byte.data != crc_reg[rtu_crc_pkg::HI_BYTE_LSB +: 8];

  // Next state of the engine
  always_comb begin
    state_next = state_reg;
    crc_next = crc_reg;
    cnt_next = cnt_reg;
    chk_hi_next = chk_hi_reg;
    lo_bad_next = lo_bad_reg;
    err_next = err_reg;
    done_next = 1'b0;
    chk_done_next = 1'b0;
    discard_next = 1'b0;
    tx_valid_next = tx_valid_reg;
    tx_data_next = tx_data_reg;
    if (i_restart) begin
      state_next = rtu_crc_pkg::st_idle;
      crc_next = rtu_crc_pkg::CRC_INIT;
      cnt_next = rtu_crc_pkg::SHIFT_FIRST;
      chk_hi_next = 1'b0;
      lo_bad_next = 1'b0;
      err_next = 1'b0;
      tx_valid_next = 1'b0;
    end else begin
      case (state_reg)
        rtu_crc_pkg::st_idle: begin
          if (take_byte && !i_byte.is_crc) begin
            // Message byte joins the low half, then eight steps follow
            crc_next = crc_reg ^ {8'h00, i_byte.data};
            cnt_next = rtu_crc_pkg::SHIFT_FIRST;
            state_next = rtu_crc_pkg::st_shift;
          end else if (take_byte && !chk_hi_reg) begin
            // Received low checksum byte, compared but not accumulated
            lo_bad_next = i_byte.data != crc_reg[rtu_crc_pkg::LO_BYTE_LSB +: 8];
            chk_hi_next = 1'b1;
          end else if (take_byte) begin
            // Received high checksum byte closes the comparison
            err_next = lo_bad_reg || hi_bad;
            discard_next = lo_bad_reg || hi_bad;
            chk_done_next = 1'b1;
            chk_hi_next = 1'b0;
            lo_bad_next = 1'b0;
          end else if (i_append) begin
            // Own result goes out unchanged, low byte first
            tx_valid_next = 1'b1;
            tx_data_next = crc_reg[rtu_crc_pkg::LO_BYTE_LSB +: 8];
            state_next = rtu_crc_pkg::st_emit_lo;
          end
        end
        rtu_crc_pkg::st_shift: begin
          crc_next = crc_stepped;
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == rtu_crc_pkg::SHIFT_LAST) begin
            done_next = 1'b1;
            state_next = rtu_crc_pkg::st_idle;
          end
        end
        rtu_crc_pkg::st_emit_lo: begin
          if (i_tx_ready) begin
            tx_data_next = crc_reg[rtu_crc_pkg::HI_BYTE_LSB +: 8];
            state_next = rtu_crc_pkg::st_emit_hi;
          end
        end
        rtu_crc_pkg::st_emit_hi: begin
          if (i_tx_ready) begin
            tx_valid_next = 1'b0;
            state_next = rtu_crc_pkg::st_idle;
          end
        end
        default: begin
          state_next = rtu_crc_pkg::st_idle;
        end
      endcase
    end
    // Parity plays no part anywhere in the accumulation
    ready_next = (state_next == rtu_crc_pkg::st_idle) && !i_append;
  end

  // State registers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_reg <= rtu_crc_pkg::st_idle;
      crc_reg <= rtu_crc_pkg::CRC_INIT;
      cnt_reg <= rtu_crc_pkg::SHIFT_FIRST;
      chk_hi_reg <= 1'b0;
      lo_bad_reg <= 1'b0;
      err_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      chk_done_reg <= 1'b0;
      discard_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      crc_reg <= crc_next;
      cnt_reg <= cnt_next;
      chk_hi_reg <= chk_hi_next;
      lo_bad_reg <= lo_bad_next;
      err_reg <= err_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      chk_done_reg <= chk_done_next;
      discard_reg <= discard_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
    end
  end

  // Outputs straight from registers
  assign o_tx_valid = tx_valid_reg;
  assign o_tx_data = tx_data_reg;
  assign o_byte_ready = ready_reg;
  assign o_byte_done = done_reg;
  assign o_crc = crc_reg;
  assign o_check_done = chk_done_reg;
  assign o_crc_error = err_reg;
  assign o_frame_discard = discard_reg;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_restart_loads_init: assert property (i_restart |=> o_crc == 16'hffff)
    else $error("accumulator not all ones after restart");

  a_byte_xor_low: assert property (take_byte && !i_byte.is_crc && !i_restart
    |=> o_crc == ($past(o_crc) ^ {8'h00, $past(i_byte.data)}))
    else $error("message byte not xored into low half");

  a_shift_step_value: assert property (state_reg == rtu_crc_pkg::st_shift && !i_restart
    |=> o_crc == ({1'b0, $past(o_crc[15:1])} ^ ($past(o_crc[0]) ? 16'ha001 : 16'h0000)))
    else $error("shift step result wrong");

  a_eight_steps_done: assert property (take_byte && !i_byte.is_crc && !i_restart
    ##1 (!i_restart) [*8] |=> o_byte_done)
    else $error("byte done not after eight steps");

  a_busy_while_shift: assert property (take_byte && !i_byte.is_crc && !i_restart
    |=> (!o_byte_ready && !o_byte_done) [*8])
    else $error("engine ready or done during shifting");

  a_low_byte_first: assert property (state_reg == rtu_crc_pkg::st_idle && i_append
    && !take_byte && !i_restart |=> o_tx_valid && o_tx_data == $past(o_crc[7:0]))
    else $error("low checksum byte not sent first");

  a_high_byte_last: assert property (state_reg == rtu_crc_pkg::st_emit_lo && i_tx_ready
    && !i_restart |=> o_tx_valid && o_tx_data == o_crc[15:8])
    else $error("high checksum byte not sent second");

  // High byte stands until the transmitter takes it, then the offer ends
  a_high_byte_holds: assert property (state_reg == rtu_crc_pkg::st_emit_hi && !i_restart
    |=> o_tx_valid == !$past(i_tx_ready) && o_tx_data == o_crc[15:8])
    else $error("high checksum byte not held until taken");

  a_mismatch_flags: assert property (take_byte && i_byte.is_crc && chk_hi_reg && hi_bad
    && !i_restart |=> o_crc_error && o_check_done)
    else $error("checksum mismatch not flagged");

  a_error_discards: assert property (o_check_done |-> o_frame_discard == o_crc_error)
    else $error("discard does not follow checksum error");

  c_byte_done: cover property (o_byte_done);
  c_check_pass: cover property (o_check_done && !o_crc_error);
  c_check_fail: cover property (o_check_done && o_crc_error);
  c_append_out: cover property (state_reg == rtu_crc_pkg::st_emit_hi && i_tx_ready);

endmodule

// ### dv/rtu_frame_crc16_engine_bench.sv
// Self-checking bench of the RTU frame checksum engine
`timescale 1ns/1ps

module rtu_frame_crc16_engine_bench;
  logic i_clk, i_resetn, i_restart, i_append, i_byte_valid, i_stall, i_tx_ready;
  logic o_tx_valid, o_byte_ready, o_byte_done, o_check_done, o_crc_error, o_frame_discard;
  logic [7:0] o_tx_data, lo, hi;
  logic [1:0] cnt;
  logic [15:0] o_crc, acc;
  rtu_crc_pkg::byte_in_type i_byte;
  int fails, checks;

  rtu_frame_crc16_engine dut (.i_clk, .i_resetn, .i_restart, .i_append, .i_byte_valid,
    .i_byte, .i_tx_ready, .o_tx_valid, .o_tx_data, .o_byte_ready, .o_byte_done, .o_crc,
    .o_check_done, .o_crc_error, .o_frame_discard);
  rtu_tx_model model (.i_clk, .i_resetn, .i_stall, .i_valid(o_tx_valid),
    .i_data(o_tx_data), .o_ready(i_tx_ready), .o_lo(lo), .o_hi(hi), .o_count(cnt));

  // Clock at 40 MHz
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Reference accumulator step, reflected form
  function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Offers one byte and holds it until the edge that sees ready
  task automatic send(input logic [7:0] d, input logic c);
    int n;
    @(posedge i_clk);
    i_byte <= '{data: d, is_crc: c};
    i_byte_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_byte_ready !== 1'b1 && n < 20);
    if (o_byte_ready !== 1'b1) begin
      fails++;
      give_verdict();
    end
    i_byte_valid <= 1'b0;
  endtask

  // Message byte, done must appear after exactly eight shift edges
  task automatic msg(input logic [7:0] d);
    send(d, 1'b0);
    acc = crc_ref(acc, d);
    repeat (7) @(posedge i_clk);
    #1;
    check("early_done", {15'h0, o_byte_done}, 16'h0);
    @(posedge i_clk);
    #1;
    check("byte_done", {15'h0, o_byte_done}, 16'h1);
    check("crc", o_crc, acc);
  endtask

  task automatic restart();
    @(posedge i_clk);
    i_restart <= 1'b1;
    @(posedge i_clk);
    i_restart <= 1'b0;
    @(posedge i_clk);
    #1;
    acc = 16'hffff;
    check("crc_init", o_crc, 16'hffff);
    check("error_clr", {15'h0, o_crc_error}, 16'h0);
  endtask

  // Sends the worked frame and appends its checksum under a stalling far side
  task automatic t_send();
    int n;
    restart();
    msg(8'h02);
    check("first", o_crc, 16'h813e);
    msg(8'h07);
    check("result", o_crc, 16'h1241);
    @(posedge i_clk);
    i_stall <= 1'b1;
    i_append <= 1'b1;
    @(posedge i_clk);
    i_append <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_stall <= 1'b0;
    #1;
    check("busy", {15'h0, o_byte_ready}, 16'h0);
    check("tx_hold_valid", {15'h0, o_tx_valid}, 16'h1);
    check("tx_hold_lo", {8'h00, o_tx_data}, 16'h0041);
    n = 0;
    while (cnt != 2'h2 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    if (cnt != 2'h2) begin
      fails++;
      give_verdict();
    end
    repeat (2) @(posedge i_clk);
    #1;
    check("tx_lo", {8'h00, lo}, 16'h0041);
    check("tx_hi", {8'h00, hi}, 16'h0012);
    check("tx_off", {15'h0, o_tx_valid}, 16'h0);
    $display("t_send done");
  endtask

  // Receives a frame with its checksum, flip spoils the high byte
  task automatic frame_check(input logic [7:0] flip);
    logic e;
    e = (flip != 8'h00);
    restart();
    msg(8'h01);
    msg(8'h03);
    msg(8'hff);
    send(acc[7:0], 1'b1);
    send(acc[15:8] ^ flip, 1'b1);
    #1;
    check("check_done", {15'h0, o_check_done}, 16'h1);
    check("crc_error", {15'h0, o_crc_error}, {15'h0, e});
    check("discard", {15'h0, o_frame_discard}, {15'h0, e});
    @(posedge i_clk);
    #1;
    check("discard_end", {15'h0, o_frame_discard}, 16'h0);
    check("error_hold", {15'h0, o_crc_error}, {15'h0, e});
  endtask

  task automatic t_good();
    frame_check(8'h00);
    $display("t_good done");
  endtask

  task automatic t_bad();
    frame_check(8'h01);
    restart();
    $display("t_bad done");
  endtask

  initial begin
    i_resetn = 1'b0;
    i_restart = 1'b0;
    i_append = 1'b0;
    i_byte_valid = 1'b0;
    i_stall = 1'b0;
    i_byte = '0;
    acc = 16'hffff;
    fails = 0;
    checks = 0;
    repeat (5) @(posedge i_clk);
    #1;
    check("reset_crc", o_crc, 16'hffff);
    check("reset_ready", {15'h0, o_byte_ready}, 16'h0);
    @(posedge i_clk);
    i_resetn <= 1'b1;
    t_send();
    t_good();
    t_bad();
    give_verdict();
  end
endmodule

// ### dv/rtu_tx_model.sv
// Transmitter side model that takes the appended checksum bytes
`timescale 1ns/1ps

module rtu_tx_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Stall request from the bench
  input wire logic i_stall,
  // Checksum byte stream
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  output logic o_ready,
  // Captured bytes
  output logic [7:0] o_lo,
  output logic [7:0] o_hi,
  output logic [1:0] o_count
);
  // Takes the low byte first and the high byte last, stalling on request
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_ready <= 1'b0;
      o_count <= 2'h0;
      o_lo <= 8'h00;
      o_hi <= 8'h00;
    end else begin
      o_ready <= !i_stall;
      if (i_valid && o_ready && o_count == 2'h0) begin
        o_lo <= i_data;
        o_count <= 2'h1;
      end else if (i_valid && o_ready && o_count == 2'h1) begin
        o_hi <= i_data;
        o_count <= 2'h2;
      end
    end
  end
endmodule

// ### include/rtu_crc_pkg.sv
// Shared constants and types of the RTU frame checksum engine
package rtu_crc_pkg;

  // Accumulator geometry and fixed values
  localparam int CRC_WIDTH = 16;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam int BYTE_WIDTH = 8;
  localparam logic [2:0] SHIFT_FIRST = 3'h0;
  localparam logic [2:0] SHIFT_LAST = 3'h7;

  // Field positions of the checksum bytes
  localparam int LO_BYTE_LSB = 0;
  localparam int HI_BYTE_LSB = 8;

  // One byte offered to the engine
  typedef struct packed {
    logic [7:0] data;
    logic is_crc;
  } byte_in_type;

  // Engine sequencing
  typedef enum logic [1:0] {
    st_idle,
    st_shift,
    st_emit_lo,
    st_emit_hi
  } state_type;

endpackage
